// *** core/axil_slave.sv ***
// axi4-lite slave turning bus transfers into register strobes
`timescale 1ns/1ns
`include "rtc_status_map.svh"
module axil_slave import rtc_status_pkg::*; #(
  parameter int ADDR_W = 8
) (
  input wire logic clock_in,
  input wire logic arst_n_in,
  input wire logic [ADDR_W-1:0] awaddr_in,
  input wire logic awvalid_in,
  output logic awready_out,
  input wire logic [31:0] wdata_in,
  input wire logic [3:0] wstrb_in,
  input wire logic wvalid_in,
  output logic wready_out,
  output resp_t bresp_out,
  output logic bvalid_out,
  input wire logic bready_in,
  input wire logic [ADDR_W-1:0] araddr_in,
  input wire logic arvalid_in,
  output logic arready_out,
  output logic [31:0] rdata_out,
  output resp_t rresp_out,
  output logic rvalid_out,
  input wire logic rready_in,
  reg_access_if.bus ra
);
  logic aw_full_q, aw_full_d, w_full_q, w_full_d, bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [ADDR_W-1:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  resp_t bresp_q, bresp_d, rresp_q, rresp_d;

  // address and data may arrive in either order; each is held until both are in
  assign awready_out = ~aw_full_q & ~bvalid_q;
  assign wready_out = ~w_full_q & ~bvalid_q;
  assign arready_out = ~rvalid_q;
  assign ra.wr_en = aw_full_q & w_full_q & ~bvalid_q;
  assign ra.wr_addr = awaddr_q;
  assign ra.wr_data = wdata_q;
  assign ra.wr_strb = wstrb_q;
  assign ra.rd_en = arvalid_in & ~rvalid_q;
  assign ra.rd_addr = araddr_in;
  assign bvalid_out = bvalid_q;
  assign bresp_out = bresp_q;
  assign rvalid_out = rvalid_q;
  assign rdata_out = rdata_q;
  assign rresp_out = rresp_q;

  always_comb begin
    aw_full_d = aw_full_q;
    w_full_d = w_full_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (awvalid_in && awready_out) begin
      aw_full_d = 1'b1;
      awaddr_d = awaddr_in;
    end
    if (wvalid_in && wready_out) begin
      w_full_d = 1'b1;
      wdata_d = wdata_in;
      wstrb_d = wstrb_in;
    end
    if (ra.wr_en) begin
      aw_full_d = 1'b0;
      w_full_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = ra.wr_err ? `RESP_SLVERR : `RESP_OKAY;
    end else if (bvalid_q && bready_in) begin
      bvalid_d = 1'b0;
    end
    if (ra.rd_en) begin
      rvalid_d = 1'b1;
      rdata_d = ra.rd_data;
      rresp_d = ra.rd_err ? `RESP_SLVERR : `RESP_OKAY;
    end else if (rvalid_q && rready_in) begin
      rvalid_d = 1'b0;
    end
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= `RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= `RESP_OKAY;
    end else begin
      aw_full_q <= aw_full_d;
      w_full_q <= w_full_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end
endmodule

// *** core/reg_access_if.sv ***
// register access strobes between the bus slave and the register bank
`timescale 1ns/1ns
interface reg_access_if #(parameter int ADDR_W = 8);
  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_err;
  logic rd_en;
  logic [ADDR_W-1:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_err;
  modport bus (output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
               input wr_err, rd_data, rd_err);
  modport regs (input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
                output wr_err, rd_data, rd_err);
endinterface

// *** core/rtc_status_flags.sv ***
// status flag register bank with axi4-lite access and interrupt output
`timescale 1ns/1ns
`include "rtc_status_map.svh"

module rtc_status_flags import rtc_status_pkg::*; #(
  parameter int ADDR_W = 8
) (
  input wire logic clock_in,
  input wire logic arst_n_in,
  input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic on_backup_pin_in,
  input wire logic write_lock_in,
  input wire logic nonvolatile_transfer_active_in,
  input wire logic clock_output_event_in,
  input wire logic update_event_in,
  input wire logic timer_event_in,
  input wire logic alarm_event_in,
  input wire logic external_event_in,
  output logic [7:0] event_status_flags_out,
  output logic timestamp_source_select_out,
  output logic timestamp_capture_enable_out,
  output logic irq_out
);
  // ***************************************************************
  // address decode
  // ***************************************************************
  function automatic reg_sel_t decode(input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-3:0] idx;
    idx = addr[ADDR_W-1:2];
    if (addr[1:0] != 2'h0) begin
      decode = SEL_NONE;
    end else if (idx == (ADDR_W-2)'(`STATUS_IDX)) begin
      decode = SEL_STATUS;
    end else if (idx == (ADDR_W-2)'(`CONTROL_IDX)) begin
      decode = SEL_CONTROL;
    end else if (idx == (ADDR_W-2)'(`PENDING_IDX)) begin
      decode = SEL_PENDING;
    end else if (idx == (ADDR_W-2)'(`MASK_IDX)) begin
      decode = SEL_MASK;
    end else begin
      decode = SEL_NONE;
    end
  endfunction

  // ***************************************************************
  // bus slave and switchover detector
  // ***************************************************************
  reg_access_if #(.ADDR_W(ADDR_W)) ra ();

  axil_slave #(.ADDR_W(ADDR_W)) u_bus (
    .clock_in(clock_in),
    .arst_n_in(arst_n_in),
    .awaddr_in(s_axi_awaddr_in),
    .awvalid_in(s_axi_awvalid_in),
    .awready_out(s_axi_awready_out),
    .wdata_in(s_axi_wdata_in),
    .wstrb_in(s_axi_wstrb_in),
    .wvalid_in(s_axi_wvalid_in),
    .wready_out(s_axi_wready_out),
    .bresp_out(s_axi_bresp_out),
    .bvalid_out(s_axi_bvalid_out),
    .bready_in(s_axi_bready_in),
    .araddr_in(s_axi_araddr_in),
    .arvalid_in(s_axi_arvalid_in),
    .arready_out(s_axi_arready_out),
    .rdata_out(s_axi_rdata_out),
    .rresp_out(s_axi_rresp_out),
    .rvalid_out(s_axi_rvalid_out),
    .rready_in(s_axi_rready_in),
    .ra(ra)
  );

  logic on_backup;
  logic switchover;

  switchover_detect u_switch (
    .clock_in(clock_in),
    .arst_n_in(arst_n_in),
    .on_backup_pin_in(on_backup_pin_in),
    .on_backup_out(on_backup),
    .switchover_out(switchover)
  );

  // ***************************************************************
  // register state
  // ***************************************************************
  flags_t status_q, status_d;
  flags_t pending_q, pending_d;
  flags_t mask_q, mask_d;
  logic [1:0] control_q, control_d;
  flags_t set_v;
  flags_t clr_v;
  reg_sel_t wr_sel, rd_sel;
  logic wr_low;
  logic status_wr;

  assign wr_sel = decode(ra.wr_addr);
  assign rd_sel = decode(ra.rd_addr);
  // only the low byte lane carries register data
  assign wr_low = ra.wr_en & ra.wr_strb[0];
  // locked status writes are answered okay but dropped whole
  assign status_wr = wr_low & (wr_sel == SEL_STATUS) & ~write_lock_in;
  assign ra.wr_err = (wr_sel == SEL_NONE);

  always_comb begin
    set_v = '0;
    set_v[`CLKOUT_BIT] = clock_output_event_in;
    set_v[`BACKUP_BIT] = switchover & ~status_q[`BACKUP_BIT];
    set_v[`UPDATE_BIT] = update_event_in;
    set_v[`TIMER_BIT] = timer_event_in;
    set_v[`ALARM_BIT] = alarm_event_in;
    set_v[`EXTEV_BIT] = external_event_in |
      (switchover & control_q[`TS_SELECT_BIT] & control_q[`TS_ENABLE_BIT]);
  end

  always_comb begin
    clr_v = '0;
    if (status_wr) begin
      clr_v = ~ra.wr_data[6:0];
      // clearing the switch flag on backup would lose the only record of the outage
      clr_v[`BACKUP_BIT] = ~ra.wr_data[`BACKUP_BIT] & ~on_backup;
    end
    // set wins over a clear in the same cycle
    status_d = (status_q & ~clr_v) | set_v;
    pending_d = pending_q | set_v;
    if (wr_low && wr_sel == SEL_PENDING) begin
      pending_d = (pending_q & ~ra.wr_data[6:0]) | set_v;
    end
    mask_d = mask_q;
    if (wr_low && wr_sel == SEL_MASK) begin
      mask_d = ra.wr_data[6:0];
    end
    control_d = control_q;
    if (wr_low && wr_sel == SEL_CONTROL) begin
      control_d = ra.wr_data[1:0];
    end
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      status_q <= `STATUS_RESET;
      pending_q <= `PENDING_RESET;
      mask_q <= `MASK_RESET;
      control_q <= `CONTROL_RESET;
    end else begin
      status_q <= status_d;
      pending_q <= pending_d;
      mask_q <= mask_d;
      control_q <= control_d;
    end
  end

  // ***************************************************************
  // read mux and outputs
  // ***************************************************************
  always_comb begin
    ra.rd_data = 32'h0;
    ra.rd_err = 1'b0;
    unique case (rd_sel)
      SEL_STATUS: begin
        ra.rd_data[7:0] = {nonvolatile_transfer_active_in, status_q};
      end
      SEL_CONTROL: begin
        ra.rd_data[1:0] = control_q;
      end
      SEL_PENDING: begin
        ra.rd_data[6:0] = pending_q;
      end
      SEL_MASK: begin
        ra.rd_data[6:0] = mask_q;
      end
      SEL_NONE: begin
        ra.rd_err = 1'b1;
      end
    endcase
  end

  assign event_status_flags_out = {nonvolatile_transfer_active_in, status_q};
  assign timestamp_source_select_out = control_q[`TS_SELECT_BIT];
  assign timestamp_capture_enable_out = control_q[`TS_ENABLE_BIT];
  assign irq_out = |(pending_q & mask_q);

  // ***************************************************************
  // assertions
  // ***************************************************************
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!arst_n_in);

  sequence status_read_s;
    s_axi_arvalid_in && s_axi_arready_out && (decode(s_axi_araddr_in) == SEL_STATUS);
  endsequence

  sequence status_back_s;
    s_axi_rvalid_out && (s_axi_rdata_out[6:0] == $past(status_q)) &&
      (s_axi_rresp_out == `RESP_OKAY);
  endsequence

  status_readback_a: assert property (status_read_s |=> status_back_s)
    else $error("status read returned wrong data");

  bsf_set_a: assert property (switchover && !status_q[`BACKUP_BIT]
    |=> status_q[`BACKUP_BIT])
    else $error("switchover did not set backup flag");

  bsf_keep_a: assert property (on_backup && status_q[`BACKUP_BIT]
    |=> status_q[`BACKUP_BIT])
    else $error("backup flag cleared while on backup");

  bsf_clear_a: assert property (status_wr && !ra.wr_data[`BACKUP_BIT] && !on_backup &&
    !switchover |=> !status_q[`BACKUP_BIT])
    else $error("backup flag not cleared on main supply");

  evf_switch_a: assert property (switchover && control_q[`TS_SELECT_BIT] &&
    control_q[`TS_ENABLE_BIT] |=> status_q[`EXTEV_BIT])
    else $error("switchover did not set event flag");

  locked_write_a: assert property (ra.wr_en && wr_sel == SEL_STATUS && write_lock_in &&
    set_v == '0 |=> $stable(status_q) && $stable(pending_q))
    else $error("locked write changed flags");

  write_answer_a: assert property (ra.wr_en |=> s_axi_bvalid_out)
    else $error("write not answered next cycle");

  irq_raise_a: assert property ((set_v & mask_q) != '0 && !(wr_low && wr_sel == SEL_MASK)
    |=> irq_out)
    else $error("unmasked event did not raise interrupt");
endmodule

// *** core/rtc_status_map.svh ***
// register offsets, field positions and reset values of the status block
`ifndef RTC_STATUS_MAP_SVH
`define RTC_STATUS_MAP_SVH
// register indices; byte address is four times the index
`define STATUS_IDX 6'h0e
`define CONTROL_IDX 6'h10
`define PENDING_IDX 6'h11
`define MASK_IDX 6'h12
// status field positions
`define NV_BUSY_BIT 7
`define CLKOUT_BIT 6
`define BACKUP_BIT 5
`define UPDATE_BIT 4
`define TIMER_BIT 3
`define ALARM_BIT 2
`define EXTEV_BIT 1
`define POR_BIT 0
// control field positions
`define TS_SELECT_BIT 0
`define TS_ENABLE_BIT 1
// reset values of the stored flags (bits 6:0) and of the control bits (1:0)
`define STATUS_RESET 7'h01
`define CONTROL_RESET 2'h0
`define PENDING_RESET 7'h00
`define MASK_RESET 7'h00
// axi responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// *** core/rtc_status_pkg.sv ***
// types shared by the status register block
package rtc_status_pkg;
  typedef logic [6:0] flags_t;
  typedef logic [1:0] resp_t;
  typedef enum logic [2:0] {
    SEL_STATUS = 3'b000,
    SEL_CONTROL = 3'b001,
    SEL_PENDING = 3'b010,
    SEL_MASK = 3'b011,
    SEL_NONE = 3'b100
  } reg_sel_t;
endpackage

// *** core/switchover_detect.sv ***
// synchronises the backup-supply indication and marks each switchover
`timescale 1ns/1ns
module switchover_detect (
  input wire logic clock_in,
  input wire logic arst_n_in,
  input wire logic on_backup_pin_in,
  output logic on_backup_out,
  output logic switchover_out
);
  logic [2:0] sync_q, sync_d;

  // stage 0 feeds only stage 1; the edge is taken between stages 1 and 2
  always_comb begin
    sync_d = {sync_q[1:0], on_backup_pin_in};
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sync_q <= 3'h0;
    end else begin
      sync_q <= sync_d;
    end
  end

  assign on_backup_out = sync_q[1];
  assign switchover_out = sync_q[1] & ~sync_q[2];
endmodule

// *** testbench/axil_host_model.sv ***
// axi4-lite host model that issues register reads and writes
`timescale 1ns/1ns
module axil_host_model (
  input wire logic clock_in,
  output logic [7:0] awaddr_out,
  output logic awvalid_out,
  input wire logic awready_in,
  output logic [31:0] wdata_out,
  output logic [3:0] wstrb_out,
  output logic wvalid_out,
  input wire logic wready_in,
  input wire logic bvalid_in,
  output logic bready_out,
  output logic [7:0] araddr_out,
  output logic arvalid_out,
  input wire logic arready_in,
  input wire logic rvalid_in,
  output logic rready_out
);
  initial begin
    awaddr_out = 8'h00;
    awvalid_out = 1'b0;
    wdata_out = 32'h0;
    wstrb_out = 4'h0;
    wvalid_out = 1'b0;
    bready_out = 1'b0;
    araddr_out = 8'h00;
    arvalid_out = 1'b0;
    rready_out = 1'b0;
  end

  // leading edge keeps two calls from touching a signal in one time step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_in);
    awaddr_out <= a;
    wdata_out <= d;
    wstrb_out <= 4'hf;
    awvalid_out <= 1'b1;
    wvalid_out <= 1'b1;
    bready_out <= 1'b1;
    do begin
      @(posedge clock_in);
      if (awvalid_out && awready_in) awvalid_out <= 1'b0;
      if (wvalid_out && wready_in) wvalid_out <= 1'b0;
    end while (!(bvalid_in && bready_out));
    bready_out <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clock_in);
    araddr_out <= a;
    arvalid_out <= 1'b1;
    rready_out <= 1'b1;
    do begin
      @(posedge clock_in);
      if (arvalid_out && arready_in) arvalid_out <= 1'b0;
    end while (!(rvalid_in && rready_out));
    rready_out <= 1'b0;
  endtask
endmodule

// *** testbench/rtc_status_flags_tb_top.sv ***
// self-checking bench of the status flag register block
`timescale 1ns/1ns
module rtc_status_flags_tb_top;
  localparam logic [7:0] status_a = 8'h38;
  localparam logic [7:0] control_a = 8'h40;
  localparam logic [7:0] pending_a = 8'h44;
  localparam logic [7:0] mask_a = 8'h48;
  logic clock_in, arst_n, pin, lock, nv;
  logic [4:0] ev;
  logic [15:0] seed;
  logic [7:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [7:0] flags;
  logic ts_sel, ts_en, irq;
  logic [33:0] rd_q[$];
  logic [1:0] wr_q[$];
  int err_count = 0;
  int cmp_count = 0;
  int cyc = 0;

  // ****************
  // instances
  // ****************
  rtc_status_flags i_rtc_status_flags (.clock_in(clock_in), .arst_n_in(arst_n),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .on_backup_pin_in(pin),
    .write_lock_in(lock), .nonvolatile_transfer_active_in(nv),
    .clock_output_event_in(ev[4]), .update_event_in(ev[3]), .timer_event_in(ev[2]),
    .alarm_event_in(ev[1]), .external_event_in(ev[0]), .event_status_flags_out(flags),
    .timestamp_source_select_out(ts_sel), .timestamp_capture_enable_out(ts_en),
    .irq_out(irq));
  axil_host_model i_axil_host_model (.clock_in(clock_in), .awaddr_out(awaddr),
    .awvalid_out(awvalid), .awready_in(awready), .wdata_out(wdata), .wstrb_out(wstrb),
    .wvalid_out(wvalid), .wready_in(wready), .bvalid_in(bvalid), .bready_out(bready),
    .araddr_out(araddr), .arvalid_out(arvalid), .arready_in(arready),
    .rvalid_in(rvalid), .rready_out(rready));

  // ****************
  // helpers
  // ****************
  function automatic logic [15:0] lfsr_next(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict;
    $display("errors %0d compares %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic w(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
    wr_q.push_back(resp);
    i_axil_host_model.wr(a, d);
  endtask

  task automatic r(input logic [7:0] a, input logic [33:0] e);
    rd_q.push_back(e);
    i_axil_host_model.rd(a);
  endtask

  // busy bit is live, so it is randomised right before each status read
  task automatic rs(input logic [6:0] e);
    @(posedge clock_in);
    seed = lfsr_next(seed);
    nv <= seed[0];
    r(status_a, {26'h0, seed[0], e});
  endtask

  task automatic pulse(input logic [4:0] v);
    @(posedge clock_in);
    ev <= v;
    @(posedge clock_in);
    ev <= 5'h00;
  endtask

  task automatic ichk(input logic e);
    @(posedge clock_in);
    #1;
    chk({33'h0, irq}, {33'h0, e});
  endtask

  // ****************
  // monitor and clock
  // ****************
  always @(posedge clock_in) begin
    if (rvalid && rready) chk({rresp, rdata}, rd_q.pop_front());
    if (bvalid && bready) chk({32'h0, bresp}, {32'h0, wr_q.pop_front()});
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      give_verdict();
    end
  end

  initial begin
    clock_in = 1'b0;
    forever #10 clock_in = ~clock_in;
  end

  // ****************
  // scenarios
  // ****************
  initial begin
    arst_n = 1'b0;
    pin = 1'b0;
    lock = 1'b0;
    nv = 1'b0;
    ev = 5'h00;
    seed = 16'd29833;
    repeat (10) @(posedge clock_in);
    arst_n <= 1'b1;
    rs(7'h01);
    r(8'h3c, {2'h2, 32'h0});
    w(8'h3c, 32'h0, 2'h2);
    w(status_a, 32'h0, 2'h0);
    rs(7'h00);
    for (int i = 0; i < 5; i++) begin
      pulse(5'h01 << i);
      rs(7'h01 << (i < 4 ? i + 1 : 6));
      w(status_a, 32'h0, 2'h0);
    end
    ichk(1'b0);
    seed = lfsr_next(seed);
    w(mask_a, {25'h0, seed[6:0]}, 2'h0);
    r(mask_a, {27'h0, seed[6:0]});
    // timer pending is still set from the loop above
    w(mask_a, 32'h08, 2'h0);
    ichk(1'b1);
    w(pending_a, 32'h7f, 2'h0);
    ichk(1'b0);
    pulse(5'h04);
    ichk(1'b1);
    w(mask_a, 32'h0, 2'h0);
    ichk(1'b0);
    @(posedge clock_in);
    pin <= 1'b1;
    repeat (6) @(posedge clock_in);
    // timer flag from the last pulse is still standing beside the switch flag
    rs(7'h28);
    w(status_a, 32'h0, 2'h0);
    rs(7'h20);
    @(posedge clock_in);
    pin <= 1'b0;
    lock <= 1'b1;
    repeat (6) @(posedge clock_in);
    w(status_a, 32'h0, 2'h0);
    rs(7'h20);
    ichk(1'b0);
    r(pending_a, {27'h0, 7'h28});
    @(posedge clock_in);
    lock <= 1'b0;
    w(status_a, 32'h0, 2'h0);
    rs(7'h00);
    w(control_a, 32'h3, 2'h0);
    r(control_a, {32'h0, 2'h3});
    @(posedge clock_in);
    pin <= 1'b1;
    repeat (6) @(posedge clock_in);
    chk({32'h0, ts_en, ts_sel}, {32'h0, 2'h3});
    rs(7'h22);
    repeat (2) @(posedge clock_in);
    #1;
    chk({26'h0, flags}, {26'h0, nv, 7'h22});
    give_verdict();
  end
endmodule
